// ---- verilog/pcs_defines.svh ----
`ifndef PCS_DEFINES_SVH
`define PCS_DEFINES_SVH

// register byte offsets
`define PCS_ADDR_W 8
`define PCS_OFF_OUT_ON 8'h04
`define PCS_OFF_OUT_OFF 8'h08
`define PCS_OFF_STATUS 8'h0c
`define PCS_OFF_IRQ_EN 8'h10
`define PCS_OFF_IRQ_DIS 8'h14
`define PCS_OFF_MASK_VIEW 8'h18

// channel bits sit at 3:0 of every channel register
`define PCS_NCH 4
`define PCS_CH_LSB 0
`define PCS_CH_MSB 3
`define PCS_RSVD_W 28

// reset values
`define PCS_OUT_RST 4'h0
`define PCS_MASK_RST 4'h0
`define PCS_DATA_RST 32'h0000_0000

// axi responses
`define PCS_RESP_OKAY 2'h0
`define PCS_RESP_SLVERR 2'h2

`endif

// ---- verilog/pcs_pkg.sv ----
package pcs_pkg;
   typedef enum logic [2:0] {
      PCS_SEL_NONE,
      PCS_SEL_OUT_ON,
      PCS_SEL_OUT_OFF,
      PCS_SEL_STATUS,
      PCS_SEL_IRQ_EN,
      PCS_SEL_IRQ_DIS,
      PCS_SEL_MASK_VIEW
   } pcs_reg_sel_t;
endpackage

// ---- verilog/pcs_bus_if.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pcs_defines.svh"

interface pcs_bus_if;
   logic wr_en;
   logic [`PCS_ADDR_W-1:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic wr_hit;
   logic [`PCS_ADDR_W-1:0] rd_addr;
   logic [31:0] rd_data;
   logic rd_hit;

   modport slave (
      output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
      input wr_hit, rd_data, rd_hit
   );
   modport regs (
      input wr_en, wr_addr, wr_data, wr_strb, rd_addr,
      output wr_hit, rd_data, rd_hit
   );
endinterface

`default_nettype wire

// ---- verilog/pcs_axil_slave.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pcs_defines.svh"

module pcs_axil_slave
   import pcs_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [`PCS_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [`PCS_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   pcs_bus_if.slave bus
);
   logic [`PCS_ADDR_W-1:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;

   // ready low means the channel's item is held here
   wire logic aw_take = s_axi_awvalid & s_axi_awready;
   wire logic w_take = s_axi_wvalid & s_axi_wready;
   wire logic b_done = s_axi_bvalid & s_axi_bready;
   wire logic ar_take = s_axi_arvalid & s_axi_arready;
   wire logic r_done = s_axi_rvalid & s_axi_rready;
   wire logic wr_fire = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;

   assign bus.wr_en = wr_fire;
   assign bus.wr_addr = awaddr_reg;
   assign bus.wr_data = wdata_reg;
   assign bus.wr_strb = wstrb_reg;
   assign bus.rd_addr = s_axi_araddr;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `PCS_RESP_OKAY;
         awaddr_reg <= '0;
         wdata_reg <= `PCS_DATA_RST;
         wstrb_reg <= 4'h0;
      end else begin
         if (aw_take) begin
            s_axi_awready <= 1'b0;
            awaddr_reg <= s_axi_awaddr;
         end
         if (w_take) begin
            s_axi_wready <= 1'b0;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= bus.wr_hit ? `PCS_RESP_OKAY : `PCS_RESP_SLVERR;
         end
         // both ready again only once the response is gone
         if (b_done) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= `PCS_DATA_RST;
         s_axi_rresp <= `PCS_RESP_OKAY;
      end else if (ar_take) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= bus.rd_data;
         s_axi_rresp <= bus.rd_hit ? `PCS_RESP_OKAY : `PCS_RESP_SLVERR;
      end else if (r_done) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule

`default_nettype wire

// ---- verilog/pcs_status_regs.sv ----
// Functional notes
// - status bit n reads one while channel n output is active; 31:4 zero
// - status bit n reads zero while channel n output is inactive
// - irq-enable write: ones turn channel interrupts on, zeros no effect
// - irq-disable write: ones turn channel interrupts off, zeros no effect
// - output-on write: ones activate channel outputs, zeros no effect
// - output-off write: ones deactivate channel outputs, zeros no effect
//
// Local design decisions: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "pcs_defines.svh"

module pcs_status_regs
   import pcs_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [`PCS_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [`PCS_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [`PCS_NCH-1:0] chan_event,
   output logic [`PCS_NCH-1:0] chan_out_active,
   output logic irq_out
);
   pcs_bus_if bus ();

   pcs_axil_slave u_slave (
      .clk(clk),
      .rst_b(rst_b),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .bus(bus.slave)
   );

   function automatic pcs_reg_sel_t decode_addr(
      input logic [`PCS_ADDR_W-1:0] addr
   );
      case (addr)
         `PCS_OFF_OUT_ON: decode_addr = PCS_SEL_OUT_ON;
         `PCS_OFF_OUT_OFF: decode_addr = PCS_SEL_OUT_OFF;
         `PCS_OFF_STATUS: decode_addr = PCS_SEL_STATUS;
         `PCS_OFF_IRQ_EN: decode_addr = PCS_SEL_IRQ_EN;
         `PCS_OFF_IRQ_DIS: decode_addr = PCS_SEL_IRQ_DIS;
         `PCS_OFF_MASK_VIEW: decode_addr = PCS_SEL_MASK_VIEW;
         default: decode_addr = PCS_SEL_NONE;
      endcase
   endfunction

   // a set-only or clear-only register touches just the bits written as one
   function automatic logic [`PCS_NCH-1:0] merge_bits(
      input logic [`PCS_NCH-1:0] cur,
      input logic [`PCS_NCH-1:0] set_bits,
      input logic [`PCS_NCH-1:0] clr_bits
   );
      merge_bits = (cur | set_bits) & ~clr_bits;
   endfunction

   logic [`PCS_NCH-1:0] out_en_reg;
   logic [`PCS_NCH-1:0] out_en_next;
   logic [`PCS_NCH-1:0] mask_reg;
   logic [`PCS_NCH-1:0] mask_next;
   logic irq_reg;
   logic irq_next;

   // write side decode
   wire pcs_reg_sel_t wr_sel = decode_addr(bus.wr_addr);
   // channel bits live in byte lane 0; other lanes hold only reserved bits
   wire logic wr_lane0 = bus.wr_en & bus.wr_strb[0];
   wire logic [`PCS_NCH-1:0] wr_bits = wr_lane0 ?
      bus.wr_data[`PCS_CH_MSB:`PCS_CH_LSB] : '0;
   wire logic [`PCS_NCH-1:0] out_set =
      (wr_sel == PCS_SEL_OUT_ON) ? wr_bits : '0;
   wire logic [`PCS_NCH-1:0] out_clr =
      (wr_sel == PCS_SEL_OUT_OFF) ? wr_bits : '0;
   wire logic [`PCS_NCH-1:0] mask_set =
      (wr_sel == PCS_SEL_IRQ_EN) ? wr_bits : '0;
   wire logic [`PCS_NCH-1:0] mask_clr =
      (wr_sel == PCS_SEL_IRQ_DIS) ? wr_bits : '0;

   // writes to read-only words are accepted and dropped
   assign bus.wr_hit = (wr_sel != PCS_SEL_NONE);

   assign out_en_next = merge_bits(out_en_reg, out_set, out_clr);
   assign mask_next = merge_bits(mask_reg, mask_set, mask_clr);
   // registered so the line cannot glitch on a mask change
   assign irq_next = |(chan_event & mask_reg);

   // read side decode; write-only words read as zero
   wire pcs_reg_sel_t rd_sel = decode_addr(bus.rd_addr);
   wire logic [31:0] status_word = {{`PCS_RSVD_W{1'b0}}, out_en_reg};
   wire logic [31:0] mask_word = {{`PCS_RSVD_W{1'b0}}, mask_reg};
   assign bus.rd_data = (rd_sel == PCS_SEL_STATUS) ? status_word :
      (rd_sel == PCS_SEL_MASK_VIEW) ? mask_word : `PCS_DATA_RST;
   assign bus.rd_hit = (rd_sel != PCS_SEL_NONE);

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         out_en_reg <= `PCS_OUT_RST;
         mask_reg <= `PCS_MASK_RST;
         irq_reg <= 1'b0;
      end else begin
         out_en_reg <= out_en_next;
         mask_reg <= mask_next;
         irq_reg <= irq_next;
      end
   end

   assign chan_out_active = out_en_reg;
   assign irq_out = irq_reg;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   wire logic out_on_wr = wr_lane0 && (wr_sel == PCS_SEL_OUT_ON);
   wire logic out_off_wr = wr_lane0 && (wr_sel == PCS_SEL_OUT_OFF);
   wire logic irq_en_wr = wr_lane0 && (wr_sel == PCS_SEL_IRQ_EN);
   wire logic irq_dis_wr = wr_lane0 && (wr_sel == PCS_SEL_IRQ_DIS);
   wire logic status_rd = s_axi_arvalid && s_axi_arready &&
      (s_axi_araddr == `PCS_OFF_STATUS);
   wire logic ar_taken = s_axi_arvalid && s_axi_arready;
   wire logic r_taken = s_axi_rvalid && s_axi_rready;
   wire logic b_taken = s_axi_bvalid && s_axi_bready;
   wire logic mask_rd = ar_taken && (s_axi_araddr == `PCS_OFF_MASK_VIEW);
   wire logic wo_rd = ar_taken && (
      (s_axi_araddr == `PCS_OFF_OUT_ON) ||
      (s_axi_araddr == `PCS_OFF_OUT_OFF) ||
      (s_axi_araddr == `PCS_OFF_IRQ_EN) ||
      (s_axi_araddr == `PCS_OFF_IRQ_DIS));
   wire logic ro_wr = bus.wr_en && ((bus.wr_addr == `PCS_OFF_STATUS) ||
      (bus.wr_addr == `PCS_OFF_MASK_VIEW));

   a_status_ones_active: assert property (
      status_rd |=> s_axi_rvalid &&
         ((s_axi_rdata[`PCS_CH_MSB:`PCS_CH_LSB] & $past(out_en_reg))
            == $past(out_en_reg)) &&
         (s_axi_rdata[31:`PCS_NCH] == '0)
   ) else $error("status misses an active channel");

   a_status_zero_idle: assert property (
      status_rd |=>
         (s_axi_rdata[`PCS_CH_MSB:`PCS_CH_LSB] & ~$past(out_en_reg)) == '0
   ) else $error("status shows an inactive channel");

   a_irq_enable_sets: assert property (
      irq_en_wr |=> ((mask_reg & $past(wr_bits)) == $past(wr_bits)) &&
         ((mask_reg & ~$past(wr_bits)) == ($past(mask_reg) & ~$past(wr_bits)))
   ) else $error("irq enable write wrong");

   a_irq_disable_clears: assert property (
      irq_dis_wr |=> ((mask_reg & $past(wr_bits)) == '0) &&
         ((mask_reg & ~$past(wr_bits)) == ($past(mask_reg) & ~$past(wr_bits)))
   ) else $error("irq disable write wrong");

   a_out_on_sets: assert property (
      out_on_wr |=> ((chan_out_active & $past(wr_bits)) == $past(wr_bits)) &&
         ((chan_out_active & ~$past(wr_bits)) ==
            ($past(out_en_reg) & ~$past(wr_bits)))
   ) else $error("output on write wrong");

   a_out_off_clears: assert property (
      out_off_wr |=> ((chan_out_active & $past(wr_bits)) == '0) &&
         ((chan_out_active & ~$past(wr_bits)) ==
            ($past(out_en_reg) & ~$past(wr_bits)))
   ) else $error("output off write wrong");

   a_out_holds_quiet: assert property (
      !out_on_wr && !out_off_wr |=> $stable(chan_out_active)
   ) else $error("outputs changed without a write");

   a_mask_holds_quiet: assert property (
      !irq_en_wr && !irq_dis_wr |=> $stable(mask_reg)
   ) else $error("mask changed without a write");

   a_irq_needs_mask: assert property (
      ##1 irq_out |-> |($past(chan_event) & $past(mask_reg))
   ) else $error("interrupt without a masked-in event");

   a_irq_follows_event: assert property (
      |(chan_event & mask_reg) |=> irq_out
   ) else $error("masked-in event did not raise interrupt");

   // the response rises on the same edge that applies the register update
   a_write_answer_time: assert property (
      bus.wr_en |=> s_axi_bvalid
   ) else $error("write response late");

   a_read_answer_hold: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
   ) else $error("read data dropped before taken");

   a_read_resp_hold: assert property (
      s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rresp)
   ) else $error("read response changed before taken");

   a_read_answer_next: assert property (
      ar_taken |=> s_axi_rvalid && !s_axi_arready
   ) else $error("read answer not in the next cycle");

   a_read_port_shut: assert property (
      s_axi_rvalid |-> !s_axi_arready
   ) else $error("read address open while data pending");

   a_read_port_reopen: assert property (
      r_taken |=> s_axi_arready && !s_axi_rvalid
   ) else $error("read address channel not reopened");

   // unmapped words answer with an error and a zero word
   a_read_miss_error: assert property (
      ar_taken && !bus.rd_hit |=>
         (s_axi_rresp == `PCS_RESP_SLVERR) && (s_axi_rdata == '0)
   ) else $error("unmapped read not refused");

   a_status_read_okay: assert property (
      status_rd |=> s_axi_rresp == `PCS_RESP_OKAY
   ) else $error("status read refused");

   a_wo_read_zero: assert property (
      wo_rd |=> (s_axi_rdata == '0) && (s_axi_rresp == `PCS_RESP_OKAY)
   ) else $error("write-only word read back non-zero");

   a_mask_view_read: assert property (
      mask_rd |=> (s_axi_rdata[31:`PCS_NCH] == '0) &&
         (s_axi_rdata[`PCS_CH_MSB:`PCS_CH_LSB] == $past(mask_reg))
   ) else $error("mask view does not show the mask");

   a_write_fires_once: assert property (
      bus.wr_en |=> !bus.wr_en
   ) else $error("one write applied twice");

   a_write_resp_hold: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)
   ) else $error("write response dropped before taken");

   a_write_ports_shut: assert property (
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready
   ) else $error("write channels open while response pending");

   a_write_ports_reopen: assert property (
      b_taken |=> s_axi_awready && s_axi_wready && !s_axi_bvalid
   ) else $error("write channels not reopened");

   a_write_hit_okay: assert property (
      bus.wr_en && bus.wr_hit |=> s_axi_bresp == `PCS_RESP_OKAY
   ) else $error("mapped write refused");

   a_write_miss_error: assert property (
      bus.wr_en && !bus.wr_hit |=> s_axi_bresp == `PCS_RESP_SLVERR
   ) else $error("unmapped write not refused");

   // strobes without lane 0 carry no channel bits, so nothing may move
   a_strobe_gates_write: assert property (
      bus.wr_en && !bus.wr_strb[0] |=>
         $stable(chan_out_active) && $stable(mask_reg)
   ) else $error("write without lane 0 changed state");

   a_ro_write_ignored: assert property (
      ro_wr |=> $stable(chan_out_active) && $stable(mask_reg)
   ) else $error("read-only word took a write");

   a_irq_quiet: assert property (
      !(|(chan_event & mask_reg)) |=> !irq_out
   ) else $error("interrupt raised while no event passes the mask");

   a_irq_masked_off: assert property (
      mask_reg == '0 |=> !irq_out
   ) else $error("interrupt with every channel masked out");

   // reset checks must run while the default disable is in force
   a_reset_clears: assert property (disable iff (1'b0)
      !rst_b |=> (chan_out_active == '0) && (mask_reg == '0) && !irq_out
   ) else $error("reset left channel state behind");

   a_reset_bus_idle: assert property (disable iff (1'b0)
      !rst_b |=> s_axi_awready && s_axi_wready && s_axi_arready &&
         !s_axi_bvalid && !s_axi_rvalid
   ) else $error("reset left the bus busy");

   c_out_on_write: cover property (out_on_wr ##1 |chan_out_active);
   c_irq_enable_write: cover property (irq_en_wr ##1 |mask_reg);
   c_irq_raised: cover property (irq_en_wr ##[1:20] irq_out);
   c_status_read: cover property (status_rd ##1 s_axi_rvalid);
   c_irq_disable_write: cover property (irq_dis_wr ##2 !irq_out);
endmodule

`default_nettype wire

// ---- bench/pcs_status_regs_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pcs_defines.svh"

module pcs_status_regs_tb
   import pcs_pkg::*;
;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic [7:0] s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [31:0] s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [3:0] chan_event = 4'h0;
   logic [3:0] chan_out_active;
   logic irq_out;
   int num_errors = 0;
   int cmp_count = 0;
   logic [3:0] exp_out = 4'h0;
   logic [3:0] exp_mask = 4'h0;
   logic [31:0] rd;
   logic [31:0] d;

   pcs_status_regs pcs_status_regs_i (
      .clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .chan_event, .chan_out_active,
      .irq_out
   );

   always #12.5 clk = ~clk;

   task automatic check(input string nm, input logic [31:0] seen,
                        input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // called just after a rising edge; address and data offered together
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] dat,
                         input logic [3:0] s, input logic [1:0] er);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= dat;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge clk);
         if (!aw_ok && s_axi_awready === 1'b1) begin
            aw_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_ok && s_axi_wready === 1'b1) begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      // raised only now so back-to-back calls never drive it twice at once
      s_axi_bready <= 1'b1;
      do @(posedge clk); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      check("bresp", 32'(s_axi_bresp), 32'(er));
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] q,
                         input logic [1:0] er);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b1;
      do @(posedge clk); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      q = s_axi_rdata;
      check("rresp", 32'(s_axi_rresp), 32'(er));
   endtask

   task automatic test_done();
      $display("compares %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // whole sequence is about a hundred cycles; this leaves ample margin
   initial begin
      repeat (5000) @(posedge clk);
      num_errors++;
      test_done();
   end

   initial begin
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      check("out_rst", 32'(chan_out_active), 32'h0);
      axi_rd(`PCS_OFF_MASK_VIEW, rd, 2'h0);
      check("mask_rst", rd, 32'h0);
      // walk one channel at a time so a swapped bit shows up
      for (int i = 0; i < 4; i++) begin
         d = 32'h1 << i;
         axi_wr(`PCS_OFF_OUT_ON, d, 4'h1, 2'h0);
         exp_out |= d[3:0];
         check("out_on", 32'(chan_out_active), 32'(exp_out));
         axi_rd(`PCS_OFF_STATUS, rd, 2'h0);
         check("status", rd, 32'(exp_out));
         axi_wr(`PCS_OFF_IRQ_EN, d, 4'h1, 2'h0);
         exp_mask |= d[3:0];
         axi_rd(`PCS_OFF_MASK_VIEW, rd, 2'h0);
         check("mask_en", rd, 32'(exp_mask));
      end
      axi_wr(`PCS_OFF_OUT_OFF, 32'h5, 4'h1, 2'h0);
      check("out_off", 32'(chan_out_active), 32'ha);
      axi_rd(`PCS_OFF_STATUS, rd, 2'h0);
      check("status_off", rd, 32'ha);
      axi_wr(`PCS_OFF_IRQ_DIS, 32'h5, 4'h1, 2'h0);
      axi_rd(`PCS_OFF_MASK_VIEW, rd, 2'h0);
      check("mask_dis", rd, 32'ha);
      // zero bits and upper bits must leave everything alone
      axi_wr(`PCS_OFF_OUT_ON, 32'hffff_fff0, 4'hf, 2'h0);
      axi_wr(`PCS_OFF_OUT_OFF, 32'hffff_fff0, 4'hf, 2'h0);
      axi_rd(`PCS_OFF_STATUS, rd, 2'h0);
      check("status_zero", rd, 32'ha);
      axi_wr(`PCS_OFF_IRQ_EN, 32'h0, 4'h1, 2'h0);
      axi_wr(`PCS_OFF_IRQ_DIS, 32'h0, 4'h1, 2'h0);
      axi_rd(`PCS_OFF_MASK_VIEW, rd, 2'h0);
      check("mask_zero", rd, 32'ha);
      axi_wr(`PCS_OFF_STATUS, 32'hf, 4'h1, 2'h0);
      check("ro_write", 32'(chan_out_active), 32'ha);
      // channel bits ride in lane 0; without its strobe nothing changes
      axi_wr(`PCS_OFF_OUT_ON, 32'h5, 4'he, 2'h0);
      check("strb_gate", 32'(chan_out_active), 32'ha);
      axi_rd(`PCS_OFF_IRQ_EN, rd, 2'h0);
      check("wo_read", rd, 32'h0);
      axi_rd(8'h40, rd, `PCS_RESP_SLVERR);
      check("unmapped", rd, 32'h0);
      axi_wr(8'h40, 32'hf, 4'hf, `PCS_RESP_SLVERR);
      // mask is 4'ha: channels 0 and 2 are masked out
      chan_event <= 4'h5;
      repeat (2) @(posedge clk);
      check("irq_masked", 32'(irq_out), 32'h0);
      chan_event <= 4'h8;
      repeat (2) @(posedge clk);
      check("irq_on", 32'(irq_out), 32'h1);
      axi_wr(`PCS_OFF_IRQ_DIS, 32'h8, 4'h1, 2'h0);
      repeat (2) @(posedge clk);
      check("irq_dis", 32'(irq_out), 32'h0);
      chan_event <= 4'h2;
      repeat (2) @(posedge clk);
      check("irq_ch1", 32'(irq_out), 32'h1);
      chan_event <= 4'h0;
      repeat (2) @(posedge clk);
      check("irq_idle", 32'(irq_out), 32'h0);
      // reset in mid-run must clear outputs and the hidden mask
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      check("out_rst2", 32'(chan_out_active), 32'h0);
      axi_rd(`PCS_OFF_MASK_VIEW, rd, 2'h0);
      check("mask_rst2", rd, 32'h0);
      test_done();
   end
endmodule

`default_nettype wire
